// File: ssp_spi_port.sv
// spi mode of the synchronous serial port: shift engine, clock divider, flags
// assumes pins come from outside (synchronised here) and software side is same-clock logic
`default_nettype none
`include "ssp_params.svh"

// What this block does
// - shift msb out, new bit into lsb
// - drive on one edge, capture on other
// - eight clocks swap both registers fully
// - full byte: buffer it, set full, irq
// - receive is double buffered
// - buffer read clears full flag
// - buffer write loads shift register directly
// - write while shifting dropped, collision flag
// - shift register only reached via buffer
// - status low six read-only, top two config
// - port runs only while enabled
// - control bits choose master or slave
// - polarity sets serial clock idle level
// - master samples in middle or at end; slave samples in middle
// - rate chosen in master; reload option
// - master clocks transfer, stops when done
// - unselected slave ignores lines, stays quiet
// - master rates: /4,/16,/64,timer2/2,reload
// - select high resets slave bit counter
// - select high floats data output at once
module ssp_spi_port #(
  parameter int RX_DEPTH = 2                            // received byte buffer entries
) (
  input  wire logic       sys_clk_in,                   // 20 MHz system clock
  input  wire logic       reset_n_in,                   // async reset, active low
  input  wire logic       clk_en_in,                    // freezes all state when low
  input  wire logic [7:0] ctrl_one_in,                  // spi_control_one value
  input  wire logic [1:0] status_cfg_in,                // spi_status_reg bits 7:6
  input  wire logic [7:0] rate_reload_in,               // rate_reload_reg value
  input  wire logic       timer2_tick_in,               // timer two output pulse
  input  wire logic       wr_strobe_in,                 // software write to buffer
  input  wire logic [7:0] wr_data_in,                   // written byte
  input  wire logic       rd_strobe_in,                 // software read of buffer
  input  wire logic       coll_clear_in,                // software clears collision flag
  input  wire logic       irq_clear_in,                 // software clears irq flag
  output logic      [7:0] data_buffer_out,              // spi_data_buffer read value
  output logic      [7:0] status_out,                   // spi_status_reg read value
  output logic            write_collision_flag_out,     // collision flag
  output logic            serial_irq_flag_out,          // byte done flag
  output logic            busy_out,                     // byte in flight
  input  wire logic       sck_pin_in,                   // serial clock pin level
  output logic            sck_pin_out,                  // serial clock drive value
  output logic            sck_pin_oe_out,               // high while driving clock
  input  wire logic       sdi_pin_in,                   // serial data in pin
  output logic            sdo_pin_out,                  // serial data out value
  output logic            sdo_pin_oe_out,               // high while driving data
  input  wire logic       sel_n_pin_in                  // slave select pin, active low
);
  import ssp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  logic       enabled;                                  // port_enable_bit
  logic       pol;                                      // idle clock level
  logic       cke;                                      // output edge select
  logic       smp;                                      // sample at end
  logic [3:0] mode;                                     // mode code
  logic       is_master;
  logic       sel_ctrl;                                 // slave with select control

  assign enabled   = ctrl_one_in[`SSP_CTL_EN_BIT];
  assign pol       = ctrl_one_in[`SSP_CTL_POL_BIT];
  assign mode      = ctrl_one_in[`SSP_CTL_MODE_HI:0];
  assign cke       = status_cfg_in[0];
  assign smp       = status_cfg_in[1];
  assign is_master = (mode == `SSP_MODE_DIV4) || (mode == `SSP_MODE_DIV16) ||
                     (mode == `SSP_MODE_DIV64) || (mode == `SSP_MODE_TMR2) ||
                     (mode == `SSP_MODE_RELOAD);
  assign sel_ctrl  = (mode == `SSP_MODE_SLV_SEL);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage only feeds the second
  logic [1:0] sck_sync;
  logic [1:0] sdi_sync;
  logic [1:0] sel_sync;
  logic       sck_prev;                                 // for edge detect
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_sync <= 2'h0;
      sdi_sync <= 2'h0;
      sel_sync <= 2'h3;
      sck_prev <= 1'b0;
    end else if (clk_en_in) begin
      sck_sync <= {sck_sync[0], sck_pin_in};
      sdi_sync <= {sdi_sync[0], sdi_pin_in};
      sel_sync <= {sel_sync[0], sel_n_pin_in};
      sck_prev <= sck_sync[1];
    end
  end
  logic sel_hi;                                         // select released
  assign sel_hi = sel_ctrl && sel_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // master rate: half period in system clocks
  function automatic logic [8:0] half_period(input logic [3:0] m, input logic [7:0] rl);
    logic [8:0] h;
    h = {1'b0, `SSP_HALF_DIV4};
    unique case (m)
      `SSP_MODE_DIV16:  h = {1'b0, `SSP_HALF_DIV16};
      `SSP_MODE_DIV64:  h = {1'b0, `SSP_HALF_DIV64};
      `SSP_MODE_RELOAD: h = {rl, 1'b0} + 9'h002;       // fosc/(4*(n+1))
      default:          h = {1'b0, `SSP_HALF_DIV4};
    endcase
    return h;
  endfunction

  logic [8:0] div_cnt;                                  // half-period counter
  logic       half_tick;                                // master half-bit strobe
  ssp_state_t state;
  logic [3:0] bit_cnt;                                  // bits done in byte
  logic [7:0] shift_reg;                                // spi_shift_reg, internal only
  logic       sck_drv;                                  // master clock level

  // divider counts while a byte is in flight in any mode but timer two; only master mode uses it
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_cnt <= 9'h000;
    end else if (clk_en_in) begin
      if (!enabled || state == SSP_IDLE) begin
        div_cnt <= 9'h000;
      end else if (mode != `SSP_MODE_TMR2) begin
        div_cnt <= half_tick ? 9'h000 : div_cnt + 9'h001;
      end
    end
  end
  // timer two output halved: each tick is one half period
  assign half_tick = is_master && (state != SSP_IDLE) &&
                     ((mode == `SSP_MODE_TMR2) ? timer2_tick_in :
                      (div_cnt + 9'h001 >= half_period(mode, rate_reload_in)));

  ////////////////////////////////////////////////////////////////////////////
  // edge events: lead edge shifts out, trail edge captures
  logic lead_ev;
  logic trail_ev;
  logic slv_rise;
  logic slv_fall;
  logic slv_lead;
  logic slv_trail;
  assign slv_rise  = sck_sync[1] && !sck_prev;
  assign slv_fall  = !sck_sync[1] && sck_prev;
  // leaving idle is the lead edge when cke=0, trail edge when cke=1
  assign slv_lead  = cke ? ((pol) ? slv_rise : slv_fall) : ((pol) ? slv_fall : slv_rise);
  assign slv_trail = cke ? ((pol) ? slv_fall : slv_rise) : ((pol) ? slv_rise : slv_fall);
  assign lead_ev   = is_master ? (half_tick && state == SSP_TRAIL)
                               : (slv_lead && !sel_hi && enabled);
  assign trail_ev  = is_master ? (half_tick && state == SSP_LEAD)
                               : (slv_trail && !sel_hi && enabled);

  // master capture waits one clock: the two-flop sdi path needs it at the fastest rate
  logic sample_bit;
  logic cap_late;                                       // master capture due now
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cap_late <= 1'b0;
    end else if (clk_en_in) begin
      cap_late <= is_master && trail_ev;
    end
  end
  assign sample_bit = sdi_sync[1];                      // end of data time sample

  logic write_ok;                                       // accepted software write
  logic byte_done;                                      // eighth bit in
  assign write_ok  = wr_strobe_in && enabled && state == SSP_IDLE &&
                     !write_collision_flag_out;
  assign byte_done = lead_ev && (bit_cnt == `SSP_BITS_PER_BYTE - 4'h1) &&
                     state == SSP_TRAIL;
  assign busy_out  = (state != SSP_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // shift sequence: lead phase waits for capture, trail phase for shift
  // cke=1: first bit already on the line at load, so shift happens on lead edges after capture
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state   <= SSP_IDLE;
      bit_cnt <= 4'h0;
    end else if (clk_en_in) begin
      if (!enabled || sel_hi) begin
        state   <= SSP_IDLE;
        bit_cnt <= 4'h0;
      end else begin
        unique case (state)
          SSP_IDLE: begin
            if (write_ok) state <= SSP_LEAD;
          end
          SSP_LEAD: begin
            if (trail_ev || (is_master && half_tick)) state <= SSP_TRAIL;
          end
          SSP_TRAIL: begin
            if (lead_ev) begin
              if (bit_cnt == `SSP_BITS_PER_BYTE - 4'h1) begin
                state   <= SSP_IDLE;
                bit_cnt <= 4'h0;
              end else begin
                state   <= SSP_LEAD;
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  // shift register: load on write, shift on lead edge after capture
  logic captured;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_reg <= `SSP_RESET_BYTE;
      captured  <= 1'b0;
    end else if (clk_en_in) begin
      if (write_ok) begin
        shift_reg <= wr_data_in;
      end else if (is_master ? cap_late : (trail_ev && state == SSP_LEAD)) begin
        captured  <= sdi_sync[1];
      end else if (lead_ev && state == SSP_TRAIL) begin
        shift_reg <= {shift_reg[6:0], (is_master && smp) ? sample_bit : captured};
      end
    end
  end

  // master clock drive: toggles on half ticks, parks at idle level
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_drv <= 1'b0;
    end else if (clk_en_in) begin
      if (!enabled || state == SSP_IDLE) sck_drv <= pol;
      else if (half_tick) sck_drv <= !sck_drv;
    end
  end
  assign sck_pin_out    = sck_drv;
  assign sck_pin_oe_out = enabled && is_master;
  assign sdo_pin_out    = shift_reg[7];
  assign sdo_pin_oe_out = enabled && !sel_hi;

  ////////////////////////////////////////////////////////////////////////////
  // received bytes pass the two-entry buffer, then to the data buffer
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_ready;
  logic       rx_full_flag;
  logic [7:0] rx_byte;
  assign rx_byte = {shift_reg[6:0], (is_master && smp) ? sample_bit : captured};
  // drain when software has emptied the data buffer or reads it now
  assign rx_ready = !rx_full_flag || rd_strobe_in;

  ssp_rx_buffer #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_buf (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (clk_en_in),
    .flush_in      (!enabled),
    .in_valid_in   (byte_done),
    .in_ready_out  (),
    .in_data_in    (rx_byte),
    .out_valid_out (rx_valid),
    .out_ready_in  (rx_ready),
    .out_data_out  (rx_data)
  );

  // data buffer, full flag; load wins over a same-cycle read clear
  logic load_buf;
  assign load_buf = rx_valid && rx_ready;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_buffer_out <= `SSP_RESET_BYTE;
      rx_full_flag    <= 1'b0;
    end else if (clk_en_in) begin
      if (write_ok) data_buffer_out <= wr_data_in;
      if (load_buf) begin
        data_buffer_out <= rx_data;
        rx_full_flag    <= 1'b1;
      end else if (rd_strobe_in || !enabled) begin
        rx_full_flag    <= 1'b0;
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      write_collision_flag_out <= 1'b0;
      serial_irq_flag_out      <= 1'b0;
    end else if (clk_en_in) begin
      if (wr_strobe_in && state != SSP_IDLE) write_collision_flag_out <= 1'b1;
      else if (coll_clear_in)               write_collision_flag_out <= 1'b0;
      if (load_buf)          serial_irq_flag_out <= 1'b1;
      else if (irq_clear_in) serial_irq_flag_out <= 1'b0;
    end
  end

  // status: top two echo config, low six read-only state
  assign status_out = {status_cfg_in, 5'h00, rx_full_flag};

  ////////////////////////////////////////////////////////////////////////////
  sequence byte_end_s;
    byte_done;
  endsequence
  full_set_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && load_buf |=> rx_full_flag && serial_irq_flag_out)
    else $error("full or irq not set on load");
  read_clear_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && rd_strobe_in && !load_buf |=> !rx_full_flag)
    else $error("read did not clear full");
  coll_set_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && wr_strobe_in && busy_out |=> write_collision_flag_out && $stable(shift_reg)
      || !clk_en_in)
    else $error("collision not flagged");
  write_load_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && write_ok |=> shift_reg == $past(wr_data_in) && busy_out)
    else $error("write did not load shift register");
  disable_idle_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && !enabled |=> !busy_out && bit_cnt == 4'h0)
    else $error("disable left engine running");
  sel_float_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    sel_hi |-> !sdo_pin_oe_out)
    else $error("data driven while deselected");
  sel_reset_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && sel_hi |=> bit_cnt == 4'h0)
    else $error("select did not reset count");
  idle_clock_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && !busy_out && enabled ##1 !busy_out |-> sck_pin_out == $past(pol))
    else $error("clock not at idle level");
  byte_count_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    byte_end_s ##0 clk_en_in |=> !busy_out && bit_cnt == 4'h0)
    else $error("byte ended at wrong count");
  status_bits_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    status_out[7:6] == status_cfg_in && status_out[0] == rx_full_flag)
    else $error("status layout wrong");
endmodule : ssp_spi_port // ssp_spi_port
`default_nettype wire

// File: ssp_params.svh
// constants for the synchronous serial port block: field positions, codes and timing
// assumes inclusion by the package and the design files by bare name
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// spi_control_one bit positions
`define SSP_CTL_COLL_BIT   7
`define SSP_CTL_EN_BIT     5
`define SSP_CTL_POL_BIT    4
`define SSP_CTL_MODE_HI    3
// spi_status_reg bit positions: two configuration bits and the full flag
`define SSP_STAT_SMP_BIT   7
`define SSP_STAT_CKE_BIT   6
`define SSP_STAT_FULL_BIT  0
// mode codes held in spi_control_one bits 3 to 0
`define SSP_MODE_DIV4      4'h0
`define SSP_MODE_DIV16     4'h1
`define SSP_MODE_DIV64     4'h2
`define SSP_MODE_TMR2      4'h3
`define SSP_MODE_SLV_SEL   4'h4
`define SSP_MODE_SLV_FREE  4'h5
`define SSP_MODE_RELOAD    4'hA
// half serial clock periods in system clocks for the fixed dividers
`define SSP_HALF_DIV4      8'h02
`define SSP_HALF_DIV16     8'h08
`define SSP_HALF_DIV64     8'h20
`define SSP_BITS_PER_BYTE  4'h8
// reset values
`define SSP_RESET_BYTE     8'h00

`endif

// File: ssp_pkg.sv
// types of the synchronous serial port block
// assumes ssp_params.svh is on the include path
`default_nettype none
`include "ssp_params.svh"
package ssp_pkg;
  // shift sequence states
  typedef enum logic [2:0] {
    SSP_IDLE  = 3'b001,
    SSP_LEAD  = 3'b010,
    SSP_TRAIL = 3'b100
  } ssp_state_t;
endpackage : ssp_pkg
`default_nettype wire

// File: ssp_rx_buffer.sv
// two-entry buffer in the received byte path, valid and ready on both sides
// assumes a single clock domain shared with the port
`default_nettype none
`include "ssp_params.svh"
module ssp_rx_buffer #(
  parameter int WIDTH = 8,                       // word width
  parameter int DEPTH = 2                        // entries, power of two
) (
  input  wire logic             sys_clk_in,      // system clock
  input  wire logic             reset_n_in,      // async reset, active low
  input  wire logic             clk_en_in,       // freeze when low
  input  wire logic             flush_in,        // drop all entries
  input  wire logic             in_valid_in,     // word offered
  output logic                  in_ready_out,    // room to accept
  input  wire logic [WIDTH-1:0] in_data_in,      // offered word
  output logic                  out_valid_out,   // word available
  input  wire logic             out_ready_in,    // drain strobe
  output logic      [WIDTH-1:0] out_data_out     // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];                 // storage flops
  logic [AW-1:0]    wr_ptr;                      // write index
  logic [AW-1:0]    rd_ptr;                      // read index
  logic [AW:0]      count;                       // fill level
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != DEPTH[AW:0]); // honest full
  assign out_valid_out = (count != '0);          // honest empty
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  // pointers and fill level; flush wins so a disable empties the path
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (clk_en_in) begin
      if (flush_in) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (push) wr_ptr <= wr_ptr + 1'b1;
        if (pop)  rd_ptr <= rd_ptr + 1'b1;
        count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
    end
  end

  // storage, no reset needed for data
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in && push && !flush_in) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // head word read straight from the storage flops; a registered copy would lag
  // one clock behind out_valid_out and hand over a stale word on the first pop
  assign out_data_out = mem[rd_ptr];

  // fill level never passes depth
  fill_bound_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    count <= DEPTH[AW:0]) else $error("buffer overfilled");
endmodule : ssp_rx_buffer // ssp_rx_buffer
`default_nettype wire

// File: ssp_slave_model.sv
// behavioural spi slave standing on the far side of the port in master mode
// assumes the master idles its clock at pol_in and drives data before the first edge
`default_nettype none
module ssp_slave_model (
  input  wire logic       sck_in,    // serial clock from the master
  input  wire logic       mosi_in,   // data from the master
  input  wire logic       sel_n_in,  // select, active low
  input  wire logic       pol_in,    // idle clock level
  input  wire logic [7:0] tx_in,     // byte loaded at selection
  output logic            miso_out,  // data to the master
  output logic      [7:0] rx_out     // shift register contents
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr;     // shift register
  logic       cap;    // bit captured on the leading edge
  logic       last;   // last bit put on the line
  ////////////////////////////////////////////////////////////////////////////////
  // load on selection; unselected, clock edges are ignored
  always @(negedge sel_n_in) sr = tx_in;
  always @(sck_in) begin
    if (!sel_n_in) begin
      if (sck_in !== pol_in) cap = mosi_in;   // leading edge captures
      else sr = {sr[6:0], cap};               // trailing edge shifts, lsb
    end
  end
  // a released line shows the inverse of its last value, never a held copy
  always @* begin
    if (!sel_n_in) last = sr[7];
    miso_out = sel_n_in ? ~last : sr[7];  // msb first
  end
  assign rx_out = sr;
endmodule // ssp_slave_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the spi port: master transfers against a slave model
// assumes ssp_spi_port and ssp_slave_model compile before this file
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] md; logic pl; logic [7:0] tx; logic [7:0] sl; int half;} ssp_row_t;
  logic       sys_clk_in = 1'b0;  // 50 ns clock
  logic       reset_n_in = 1'b0;  // async reset
  logic [7:0] ctrl = 8'h00;       // control one
  logic [1:0] cfg = 2'h0;         // status config bits
  logic       wr = 1'b0, rd = 1'b0, cclr = 1'b0, iclr = 1'b0, sel_n = 1'b1;
  logic [7:0] wd = 8'h00, sl_tx = 8'h00, sl_rx, dbuf, stat;
  logic       coll, irq, busy, sck, sck_oe, sdo, sdo_oe, miso;
  logic [1:0] tcnt = 2'h0;        // timer two tick divider
  int         err_total = 0, n_tests = 0;
  ssp_row_t   rows[5] = '{'{4'h0, 1'b0, 8'hA5, 8'h3C, 2}, '{4'h1, 1'b1, 8'h81, 8'h7E, 8},
                          '{4'h2, 1'b0, 8'h01, 8'hFE, 32}, '{4'h3, 1'b1, 8'hC3, 8'h5A, 4},
                          '{4'hA, 1'b0, 8'h96, 8'h69, 8}};
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) tcnt <= tcnt + 2'h1;
  ////////////////////////////////////////////////////////////////////////////////
  ssp_spi_port dut_u (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
    .ctrl_one_in(ctrl), .status_cfg_in(cfg), .rate_reload_in(8'h03),
    .timer2_tick_in(tcnt == 2'h3), .wr_strobe_in(wr), .wr_data_in(wd), .rd_strobe_in(rd),
    .coll_clear_in(cclr), .irq_clear_in(iclr), .data_buffer_out(dbuf), .status_out(stat),
    .write_collision_flag_out(coll), .serial_irq_flag_out(irq), .busy_out(busy),
    .sck_pin_in(sck_oe ? sck : 1'b0), .sck_pin_out(sck), .sck_pin_oe_out(sck_oe),
    .sdi_pin_in(miso), .sdo_pin_out(sdo), .sdo_pin_oe_out(sdo_oe), .sel_n_pin_in(sel_n));
  ssp_slave_model slave_u (.sck_in(sck), .mosi_in(sdo), .sel_n_in(sel_n), .pol_in(ctrl[4]),
    .tx_in(sl_tx), .miso_out(miso), .rx_out(sl_rx));
  ////////////////////////////////////////////////////////////////////////////////
  // move inputs a fixed 5 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #5;
  endtask
  task automatic conclude();
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one whole byte as master; a second write lands mid-byte when hit is set
  task automatic xfer(input ssp_row_t r, input logic hit);
    int n;
    n = 0;
    ctrl = 8'h00;
    sl_tx = r.sl;
    step(1);
    ctrl = {2'b00, 1'b1, r.pl, r.md};
    step(3);
    chk("sck_idle", {7'h00, r.pl}, {7'h00, sck});
    // select only once the clock has parked, so a polarity change is no edge
    sel_n = 1'b0;                               // one slave at a time
    wr = 1'b1;
    wd = r.tx;
    step(1);
    wr = 1'b0;
    while (busy !== 1'b0 && n < 5000) begin
      wr = hit && n == 4;
      wd = ~r.tx;
      n++;
      step(1);
    end
    if (n == 5000) begin
      err_total++;
      conclude();
    end
    chk("busy_len", 8'h01, {7'h00, n >= 15 * r.half && n <= 17 * r.half + 4});
    step(4);
    chk("rx_byte", r.sl, dbuf);
    chk("slave_rx", r.tx, sl_rx);
    chk("irq", 8'h01, {7'h00, irq});
    chk("status", {cfg, 6'h01}, stat);
    rd = 1'b1;
    iclr = 1'b1;
    step(1);
    rd = 1'b0;
    iclr = 1'b0;
    step(1);
    chk("full_clr", {cfg, 6'h00}, stat);
    sel_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    step(20);
    reset_n_in = 1'b1;
    step(3);
    chk("rst_status", 8'h00, stat);
    chk("rst_flags", 8'h00, {6'h00, coll, irq});
    foreach (rows[i]) xfer(rows[i], 1'b0);
    // write while shifting is dropped and flagged, later writes refused
    cfg = 2'h2;                                // sample at end of data time
    xfer(rows[0], 1'b1);
    chk("coll", 8'h01, {7'h00, coll});
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
    chk("refused", 8'h00, {7'h00, busy});
    cclr = 1'b1;
    step(1);
    cclr = 1'b0;
    step(1);
    chk("coll_clr", 8'h00, {7'h00, coll});
    // slave with select: released select floats the data output
    ctrl = 8'h24;
    step(4);
    chk("sdo_float", 8'h00, {7'h00, sdo_oe});
    chk("slv_sck_oe", 8'h00, {7'h00, sck_oe});
    sel_n = 1'b0;
    step(4);
    chk("sdo_drive", 8'h01, {7'h00, sdo_oe});
    sel_n = 1'b1;
    ctrl = 8'h00;
    step(2);
    chk("off_sck_oe", 8'h00, {7'h00, sck_oe});
    chk("off_busy", 8'h00, {7'h00, busy});
    conclude();
  end
endmodule // tb_top
`default_nettype wire
